// >>> hdl/i2c_exp_master.sv
// Bus master end: turns start, byte and stop commands into bus waveforms.
`timescale 1ns/1ps
module i2c_exp_master
	import i2c_exp_pkg::*;
#(
	parameter int QUARTER_CYCLES = QUARTER_CYC
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// Bus
	i2c_exp_if.master bus,
	// Command port
	input wire logic cmdValid,
	output logic cmdReady,
	input wire bus_cmd_t cmd,
	input wire logic [7:0] cmdData,
	input wire logic cmdAck,
	// Response port
	output logic rspValid,
	output logic [7:0] rspData,
	output logic rspNack
);
	localparam int QW = (QUARTER_CYCLES < 2) ? 1 : $clog2(QUARTER_CYCLES);

	typedef enum {M_IDLE, M_START, M_BIT, M_STOP} mstate_t;

	mstate_t state, next_state;
	logic [QW-1:0] qCnt, next_qCnt;
	logic [1:0] quarter, next_quarter;
	logic [3:0] bitIdx, next_bitIdx;
	logic [7:0] shreg, next_shreg;
	logic isRead, next_isRead;
	logic ackBit, next_ackBit;
	logic sclLow, next_sclLow;
	logic sdaLow, next_sdaLow;
	logic sampled, next_sampled;
	logic next_rspValid;
	logic [7:0] next_rspData;
	logic next_rspNack;
	logic tick;

	assign cmdReady = (state == M_IDLE);
	assign tick = (qCnt == QW'(QUARTER_CYCLES - 1));
	assign bus.sclOut = 1'b0;
	assign bus.sclOe = sclLow; // [RQ6]
	assign bus.sdaOutM = 1'b0;
	assign bus.sdaOeM = sdaLow;

	always_comb begin
		next_state = state;
		next_qCnt = (state == M_IDLE || tick) ? '0 : qCnt + QW'(1);
		next_quarter = tick ? quarter + 2'h1 : quarter;
		next_bitIdx = bitIdx;
		next_shreg = shreg;
		next_isRead = isRead;
		next_ackBit = ackBit;
		next_sclLow = sclLow;
		next_sdaLow = sdaLow;
		next_sampled = sampled;
		next_rspValid = 1'b0;
		next_rspData = rspData;
		next_rspNack = rspNack;
		unique case (state)
			M_IDLE: begin
				next_quarter = 2'h0;
				if (cmdValid) begin
					next_bitIdx = 4'h0;
					next_shreg = cmdData;
					next_isRead = (cmd == CMD_READ);
					next_ackBit = cmdAck;
					unique case (cmd)
						CMD_START: next_state = M_START;
						CMD_STOP: next_state = M_STOP;
						CMD_WRITE, CMD_READ: next_state = M_BIT;
					endcase
				end
			end
			M_START: if (tick) begin // [RQ1] [RQ19]
				unique case (quarter)
					2'h0: next_sdaLow = 1'b0;
					2'h1: next_sclLow = 1'b0;
					2'h2: next_sdaLow = 1'b1;
					2'h3: begin
						next_sclLow = 1'b1;
						next_state = M_IDLE;
					end
				endcase
			end
			M_STOP: if (tick) begin // [RQ1]
				unique case (quarter)
					2'h0: next_sdaLow = 1'b1;
					2'h1: next_sclLow = 1'b0;
					2'h2: next_sdaLow = 1'b0;
					2'h3: next_state = M_IDLE;
				endcase
			end
			M_BIT: if (tick) begin // [RQ2] [RQ3]
				unique case (quarter)
					2'h0: begin
						if (bitIdx == BITS_PER_BYTE) begin
							next_sdaLow = isRead && ackBit; // [RQ4]
						end else begin
							next_sdaLow = !isRead && !shreg[7];
						end
					end
					2'h1: next_sclLow = 1'b0;
					2'h2: begin
						next_sampled = bus.sda;
						if (isRead && bitIdx != BITS_PER_BYTE) begin
							next_shreg = {shreg[6:0], bus.sda};
						end
					end
					2'h3: begin
						next_sclLow = 1'b1;
						next_bitIdx = bitIdx + 4'h1;
						if (!isRead && bitIdx != BITS_PER_BYTE) begin
							next_shreg = {shreg[6:0], 1'b0};
						end
						if (bitIdx == BITS_PER_BYTE) begin
							next_state = M_IDLE;
							next_rspValid = 1'b1;
							next_rspData = shreg;
							next_rspNack = !isRead && sampled;
						end
					end
				endcase
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			state <= M_IDLE;
			qCnt <= '0;
			quarter <= 2'h0;
			bitIdx <= 4'h0;
			shreg <= 8'h00;
			isRead <= 1'b0;
			ackBit <= 1'b0;
			sclLow <= 1'b0;
			sdaLow <= 1'b0;
			sampled <= 1'b1;
			rspValid <= 1'b0;
			rspData <= 8'h00;
			rspNack <= 1'b0;
		end else begin
			state <= next_state;
			qCnt <= next_qCnt;
			quarter <= next_quarter;
			bitIdx <= next_bitIdx;
			shreg <= next_shreg;
			isRead <= next_isRead;
			ackBit <= next_ackBit;
			sclLow <= next_sclLow;
			sdaLow <= next_sdaLow;
			sampled <= next_sampled;
			rspValid <= next_rspValid;
			rspData <= next_rspData;
			rspNack <= next_rspNack;
		end
	end
endmodule : i2c_exp_master

// >>> hdl/i2c_exp_slave.sv
// Expander end: address match, command pointer, register access and timeout.
`timescale 1ns/1ps
module i2c_exp_slave
	import i2c_exp_pkg::*;
#(
	parameter int TIMEOUT_CYCLES = TIMEOUT_CYC,
	parameter int GLITCH_CYCLES = GLITCH_CYC
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// Bus
	i2c_exp_if.device bus,
	// Address strap: 0 ground, 1 supply, 2 data line, 3 clock line
	input wire logic [1:0] address_select_pin,
	// Register access toward the port logic
	output logic [7:0] regAddr,
	output logic [7:0] regWdata,
	output logic regWe,
	output logic regRe,
	input wire logic [7:0] regRdata,
	// Interrupt
	input wire logic portEvent,
	output logic intPull,
	output logic timeoutFlag
);
	localparam int TW = $clog2(TIMEOUT_CYCLES + 1);
	localparam int FW = $clog2(GLITCH_CYCLES + 2);

	typedef enum {S_IDLE, S_RX, S_ACK, S_TX, S_MACK} sstate_t;
	typedef enum {PH_ADDR, PH_CMD, PH_DATA} phase_t;

	// Line index 0 is the clock, 1 is data.
	logic [1:0] syncA, syncB;
	logic [1:0] filt, next_filt;
	logic [1:0] prevFilt;
	logic [FW-1:0] fCnt [2];
	logic [FW-1:0] next_fCnt [2];

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			syncA <= 2'h3;
			syncB <= 2'h3;
		end else begin
			syncA <= {bus.sda, bus.scl}; // [RQ23]
			syncB <= syncA;
		end
	end

	always_comb begin
		for (int i = 0; i < 2; i++) begin
			next_filt[i] = filt[i];
			next_fCnt[i] = '0;
			if (syncB[i] != filt[i]) begin // [RQ23]
				next_fCnt[i] = fCnt[i] + FW'(1);
				if (fCnt[i] == FW'(GLITCH_CYCLES - 1)) begin
					next_filt[i] = syncB[i];
					next_fCnt[i] = '0;
				end
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			filt <= 2'h3;
			prevFilt <= 2'h3;
			fCnt[0] <= '0;
			fCnt[1] <= '0;
		end else begin
			filt <= next_filt;
			prevFilt <= filt;
			fCnt[0] <= next_fCnt[0];
			fCnt[1] <= next_fCnt[1];
		end
	end

	logic sclRise, sclFall, startCond, stopCond;
	assign sclRise = filt[0] && !prevFilt[0];
	assign sclFall = !filt[0] && prevFilt[0];
	assign startCond = filt[0] && prevFilt[0] && prevFilt[1] && !filt[1]; // [RQ1]
	assign stopCond = filt[0] && prevFilt[0] && !prevFilt[1] && filt[1]; // [RQ1]

	sstate_t state, next_state;
	phase_t phase, next_phase;
	logic [3:0] bitCnt, next_bitCnt;
	logic [7:0] shreg, next_shreg;
	logic [7:0] ptr, next_ptr;
	logic [7:0] cfgReg, next_cfgReg;
	logic isRead, next_isRead;
	logic drive, next_drive;
	logic flag, next_flag;
	logic [TW-1:0] toCnt, next_toCnt;
	logic [1:0] strap;
	logic strapDone;
	logic [7:0] rdByte;
	logic toExpire, loadTx, setFlag, clrFlag;

	// The strap is caught on the first clock after reset so that a strap to a bus line is seen idle-high.
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			strap <= 2'h0;
			strapDone <= 1'b0;
		end else if (!strapDone) begin
			strap <= address_select_pin; // [RQ8]
			strapDone <= 1'b1;
		end
	end

	assign rdByte = (ptr == REG_CONFIG) ? cfgReg :
		(ptr == REG_TIMEOUT_FLAG) ? {7'h00, flag} : regRdata;
	assign toExpire = !cfgReg[CFG_TIMEOUT_DIS_BIT] && state != S_IDLE &&
		toCnt == TW'(TIMEOUT_CYCLES); // [RQ10] [RQ12]
	assign regAddr = ptr;
	assign regWdata = shreg;
	assign bus.sdaOutS = 1'b0;
	assign bus.sdaOeS = drive; // [RQ5]
	assign timeoutFlag = flag;
	assign intPull = flag || portEvent; // [RQ13]

	always_comb begin
		next_state = state;
		next_phase = phase;
		next_bitCnt = bitCnt;
		next_shreg = shreg;
		next_ptr = ptr;
		next_cfgReg = cfgReg;
		next_isRead = isRead;
		next_drive = drive;
		next_toCnt = (sclRise || sclFall || state == S_IDLE) ? '0 : toCnt + TW'(1);
		regWe = 1'b0;
		regRe = 1'b0;
		loadTx = 1'b0;
		setFlag = 1'b0;
		clrFlag = 1'b0;
		if (startCond) begin // [RQ9] [RQ11]
			next_state = S_RX;
			next_phase = PH_ADDR;
			next_bitCnt = 4'h0;
			next_drive = 1'b0;
		end else if (stopCond) begin // [RQ15]
			next_state = S_IDLE;
			next_drive = 1'b0;
		end else if (toExpire) begin // [RQ10] [RQ11]
			next_state = S_IDLE;
			next_drive = 1'b0;
			setFlag = 1'b1;
		end else begin
			unique case (state)
				S_IDLE: next_drive = 1'b0;
				S_RX: begin
					if (sclRise && bitCnt != BITS_PER_BYTE) begin // [RQ2]
						next_shreg = {shreg[6:0], filt[1]};
						next_bitCnt = bitCnt + 4'h1;
					end else if (sclFall && bitCnt == BITS_PER_BYTE) begin
						next_state = S_ACK;
						next_drive = 1'b1; // [RQ3] [RQ4]
						unique case (phase)
							PH_ADDR: begin
								if (shreg[7:1] == {ADDR_FIXED, strap, 1'b0}) begin // [RQ7] [RQ8]
									next_isRead = shreg[0];
									next_phase = shreg[0] ? PH_DATA : PH_CMD;
								end else begin
									next_state = S_IDLE; // [RQ9]
									next_drive = 1'b0;
								end
							end
							PH_CMD: begin
								next_ptr = shreg; // [RQ14]
								next_phase = PH_DATA;
							end
							PH_DATA: begin
								if (ptr == REG_CONFIG) begin
									next_cfgReg = shreg; // [RQ12]
								end else if (ptr != REG_TIMEOUT_FLAG) begin
									regWe = 1'b1; // [RQ16]
								end
								next_ptr = nextPtr(ptr); // [RQ20]
							end
						endcase
					end
				end
				S_ACK: if (sclFall) begin
					next_drive = 1'b0;
					next_bitCnt = 4'h0;
					if (isRead) begin
						loadTx = 1'b1;
					end else begin
						next_state = S_RX;
					end
				end
				S_TX: if (sclFall) begin
					next_bitCnt = bitCnt + 4'h1;
					if (bitCnt == BITS_PER_BYTE - 4'h1) begin
						next_state = S_MACK;
						next_drive = 1'b0;
					end else begin
						next_shreg = {shreg[6:0], 1'b0};
						next_drive = !shreg[6]; // [RQ2]
					end
				end
				S_MACK: begin
					if (sclRise && bitCnt == BITS_PER_BYTE) begin // [RQ4]
						next_ptr = nextPtr(ptr); // [RQ17] [RQ20]
						next_bitCnt = bitCnt + 4'h1;
						if (filt[1]) begin
							next_state = S_IDLE; // [RQ22]
						end
					end else if (sclFall && bitCnt != BITS_PER_BYTE) begin
						loadTx = 1'b1;
					end
				end
			endcase
		end
		if (loadTx) begin // [RQ17]
			next_state = S_TX;
			next_bitCnt = 4'h0;
			next_shreg = rdByte;
			next_drive = !rdByte[7];
			regRe = (ptr != REG_CONFIG) && (ptr != REG_TIMEOUT_FLAG);
			clrFlag = (ptr == REG_TIMEOUT_FLAG); // [RQ21]
		end
		next_flag = setFlag || (flag && !clrFlag); // [RQ13] [RQ21]
	end

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			state <= S_IDLE;
			phase <= PH_ADDR;
			bitCnt <= 4'h0;
			shreg <= 8'h00;
			ptr <= 8'h00;
			cfgReg <= CONFIG_RESET;
			isRead <= 1'b0;
			drive <= 1'b0;
			flag <= 1'b0;
			toCnt <= '0;
		end else begin
			state <= next_state;
			phase <= next_phase;
			bitCnt <= next_bitCnt;
			shreg <= next_shreg;
			ptr <= next_ptr;
			cfgReg <= next_cfgReg;
			isRead <= next_isRead;
			drive <= next_drive;
			flag <= next_flag;
			toCnt <= next_toCnt;
		end
	end
endmodule : i2c_exp_slave

// >>> shared/i2c_exp_if.sv
// Two-wire bus joining the master end and the expander end.
`timescale 1ns/1ps
interface i2c_exp_if;
	logic sclOut;
	logic sclOe;
	logic sdaOutM;
	logic sdaOeM;
	logic sdaOutS;
	logic sdaOeS;
	wire scl;
	wire sda;

	// Open-drain resolution with pull-ups: any enabled low driver wins.
	assign scl = (sclOe && !sclOut) ? 1'b0 : 1'b1;
	assign sda = ((sdaOeM && !sdaOutM) || (sdaOeS && !sdaOutS)) ? 1'b0 : 1'b1;

	modport master (input scl, input sda, output sclOut, output sclOe,
		output sdaOutM, output sdaOeM);
	modport device (input scl, input sda, output sdaOutS, output sdaOeS);
endinterface : i2c_exp_if

// >>> shared/i2c_exp_pkg.sv
// Constants and types shared by both ends of the expander serial port.
// Functional notes
// RQ1: Detect START and STOP at any time.
// RQ2: One bit per clock, stable while high.
// RQ3: Ninth clock carries receiver's low acknowledge.
// RQ4: Device acknowledges writes; master acknowledges reads.
// RQ5: Device never drives clock; data open-drain only.
// RQ6: Master starts transfers and makes all clocks.
// RQ7: Address is fixed 0111 plus direction bit.
// RQ8: Select strap sets address bits; next bit zero.
// RQ9: Acknowledge matching address only, else ignore traffic.
// RQ10: Enabled timeout over 20ms aborts and releases data.
// RQ11: After timeout, wait for a fresh START.
// RQ12: Configuration bit enables or disables timeout.
// RQ13: Interrupt from timeout or port event, read-cleared.
// RQ14: First written byte becomes the command pointer.
// RQ15: STOP after command keeps pointer, writes nothing.
// RQ16: Data bytes go to pointer, then following registers.
// RQ17: Reads use pointer, advancing after each byte.
// RQ18: Master sets pointer before reading or rereading.
// RQ19: Multi-master reads use repeated START after pointer.
// RQ20: Pointer advances only within 0x31 to 0x5B.
// RQ21: Read-only timeout flag; reading clears its interrupt.
// RQ22: On master no-acknowledge, release data and wait.
// RQ23: Synchronise and deglitch both lines before use.
package i2c_exp_pkg;
	localparam int CLK_HZ = 20_000_000;
	localparam int TIMEOUT_MS = 20;
	localparam int TIMEOUT_CYC = (CLK_HZ / 1000) * TIMEOUT_MS;
	localparam int GLITCH_NS = 50;
	localparam int GLITCH_RAW = (GLITCH_NS * (CLK_HZ / 1_000_000)) / 1000;
	localparam int GLITCH_CYC = (GLITCH_RAW < 1) ? 1 : GLITCH_RAW;
	localparam int BUS_HZ = 100_000;
	localparam int QUARTER_CYC = CLK_HZ / (4 * BUS_HZ);
	localparam logic [3:0] ADDR_FIXED = 4'h7;
	localparam logic [7:0] REG_CONFIG = 8'h01;
	localparam logic [7:0] REG_TIMEOUT_FLAG = 8'h48;
	localparam logic [7:0] PTR_FIRST = 8'h31;
	localparam logic [7:0] PTR_LAST = 8'h5b;
	localparam logic [7:0] CONFIG_RESET = 8'h0a;
	localparam int CFG_TIMEOUT_DIS_BIT = 0;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;

	typedef enum logic [1:0] {CMD_START, CMD_WRITE, CMD_READ, CMD_STOP} bus_cmd_t;

	// Pointer advance wraps inside the autoincrement window and holds outside it.
	function automatic logic [7:0] nextPtr(input logic [7:0] p);
		if (p == PTR_LAST) begin
			return PTR_FIRST;
		end
		if (p >= PTR_FIRST && p < PTR_LAST) begin
			return p + 8'h01;
		end
		return p;
	endfunction : nextPtr
endpackage : i2c_exp_pkg

// >>> testbench/i2c_exp_checker.sv
// Protocol checks on the two-wire bus between the master and expander ends.
`timescale 1ns/1ps
module i2c_exp_checker #(
	parameter int TIMEOUT_CYCLES = 2000
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// Bus lines and drivers
	input wire scl,
	input wire sda,
	input wire logic sdaOutS,
	input wire logic sdaOeS,
	input wire logic sdaOeM
);
	localparam int TO_LIMIT = TIMEOUT_CYCLES + 8;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);
	logic sclQ;
	logic sdaQ;
	logic rwBit;
	logic first;
	logic [3:0] bitCnt;
	int gap;
	// Tracks the clock count within a byte and the gap between clock edges.
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			sclQ <= 1'b1;
			sdaQ <= 1'b1;
			rwBit <= 1'b0;
			first <= 1'b0;
			bitCnt <= 4'h0;
			gap <= 0;
		end else begin
			sclQ <= scl;
			sdaQ <= sda;
			gap <= (scl != sclQ) ? 0 : gap + 1;
			if (scl && sclQ && sdaQ && !sda) begin
				bitCnt <= 4'h0;
				first <= 1'b1;
			end else if (scl && !sclQ) begin
				bitCnt <= (bitCnt == 4'h9) ? 4'h1 : bitCnt + 4'h1;
				if (bitCnt == 4'h9) begin
					first <= 1'b0;
				end
				if (bitCnt == 4'h7) begin
					rwBit <= sda;
				end
			end
		end
	end
	pull_only_a: assert property (sdaOeS |-> !sdaOutS)
		else $error("device drives data high");
	dev_hold_a: assert property (scl && sclQ |-> $stable(sdaOeS))
		else $error("device data changed while clock high");
	start_master_a: assert property (scl && sclQ && sdaQ && !sda |-> sdaOeM)
		else $error("start not made by master");
	no_clash_a: assert property (scl && sclQ |-> !(sdaOeS && sdaOeM))
		else $error("both ends drive data");
	stop_free_a: assert property (scl && sclQ && !sdaQ && sda |=> (!sdaOeS) [*4])
		else $error("device drives after stop");
	addr_quiet_a: assert property (scl && sclQ && first && bitCnt != 4'h9 |-> !sdaOeS)
		else $error("device drives during address");
	ack_end_a: assert property ($fell(scl) && first && bitCnt == 4'h9 && !rwBit
		|-> ##[1:8] !sdaOeS)
		else $error("address ack not released");
	timeout_rel_a: assert property (gap > TO_LIMIT |-> !sdaOeS)
		else $error("data held past timeout");
	addr_ack_c: cover property (scl && sclQ && first && bitCnt == 4'h9 && sdaOeS);
	stall_c: cover property (gap > TO_LIMIT);
	stop_c: cover property (scl && sclQ && !sdaQ && sda);
endmodule : i2c_exp_checker

// >>> testbench/tb_top.sv
// Self-checking bench joining the master and expander ends over the shared bus.
`timescale 1ns/1ps
module tb_top;
	import i2c_exp_pkg::*;
	localparam int TO_CYC = 2000;
	logic mclk = 1'b0;
	logic rst_b = 1'b0;
	logic cmdValid = 1'b0;
	logic cmdReady;
	bus_cmd_t cmd = CMD_STOP;
	logic [7:0] cmdData = 8'h00;
	logic cmdAck = 1'b0;
	logic rspValid;
	logic [7:0] rspData;
	logic rspNack;
	logic [1:0] strap = 2'h0;
	logic [7:0] regAddr;
	logic [7:0] regWdata;
	logic regWe;
	logic regRe;
	logic [7:0] regRdata;
	logic portEvent = 1'b0;
	logic intPull;
	logic timeoutFlag;
	logic nk;
	logic [7:0] q;
	logic [7:0] mem [256] = '{default: 8'h00};
	logic [31:0] seed = 32'hbde6b49b;
	int expMem [256];
	int wq [$];
	int ptr;
	int cfg;
	int flag;
	int reCnt = 0;
	int reExp = 0;
	int error_cnt = 0;
	int total_checks = 0;
	i2c_exp_if busIf ();
	i2c_exp_master #(.QUARTER_CYCLES(5)) i2c_exp_master_inst (.mclk(mclk), .rst_b(rst_b),
		.bus(busIf.master), .cmdValid(cmdValid), .cmdReady(cmdReady), .cmd(cmd),
		.cmdData(cmdData), .cmdAck(cmdAck), .rspValid(rspValid), .rspData(rspData),
		.rspNack(rspNack));
	i2c_exp_slave #(.TIMEOUT_CYCLES(TO_CYC), .GLITCH_CYCLES(1)) i2c_exp_slave_inst (
		.mclk(mclk), .rst_b(rst_b), .bus(busIf.device), .address_select_pin(strap),
		.regAddr(regAddr), .regWdata(regWdata), .regWe(regWe), .regRe(regRe),
		.regRdata(regRdata), .portEvent(portEvent), .intPull(intPull),
		.timeoutFlag(timeoutFlag));
	i2c_exp_checker #(.TIMEOUT_CYCLES(TO_CYC)) i2c_exp_checker_inst (.mclk(mclk),
		.rst_b(rst_b), .scl(busIf.scl), .sda(busIf.sda), .sdaOutS(busIf.sdaOutS),
		.sdaOeS(busIf.sdaOeS), .sdaOeM(busIf.sdaOeM));
	assign regRdata = mem[regAddr];
	initial begin
		forever #25 mclk = ~mclk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// Port-logic stand-in: stores every register write and checks it against the model.
	always @(posedge mclk) begin
		if (regWe === 1'b1) begin
			mem[regAddr] <= regWdata;
			chk({regAddr, regWdata}, (wq.size() > 0) ? wq.pop_front() : -1);
		end
		// Each outside read must fetch the byte the model pointer names.
		if (regRe === 1'b1) begin
			reCnt++;
			chk(regAddr, ptr);
		end
	end
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	function automatic int adv(input int p);
		if (p == 8'h5b) begin
			return 8'h31;
		end
		return (p >= 8'h31 && p < 8'h5b) ? p + 1 : p;
	endfunction : adv
	task automatic close_out();
		$display("Checks %0d, mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : close_out
	task automatic issue(input bus_cmd_t c, input logic [7:0] d, input logic a);
		int n;
		n = 0;
		cmd <= c;
		cmdData <= d;
		cmdAck <= a;
		cmdValid <= 1'b1;
		do begin
			@(posedge mclk);
			n++;
		end while (cmdReady !== 1'b1 && n < 3000);
		cmdValid <= 1'b0;
		do begin
			@(posedge mclk);
			n++;
		end while ((c == CMD_START || c == CMD_STOP ? cmdReady : rspValid) !== 1'b1 && n < 3000);
		nk = rspNack;
		q = rspData;
		if (n >= 3000) begin
			error_cnt++;
			$display("Error at %0t: command stalled, count %h limit %h", $time, n, 3000);
		end
	endtask : issue
	task automatic doReset();
		rst_b <= 1'b0;
		repeat (10) @(posedge mclk);
		rst_b <= 1'b1;
		repeat (8) @(posedge mclk);
		cfg = 8'h0a;
		flag = 0;
	endtask : doReset
	task automatic setPtr(input int p, input bit stop);
		issue(CMD_START, 8'h00, 1'b0);
		issue(CMD_WRITE, {4'h7, strap, 2'b00}, 1'b0);
		chk(nk, 0);
		issue(CMD_WRITE, p[7:0], 1'b0);
		chk(nk, 0);
		ptr = p;
		if (stop) begin
			issue(CMD_STOP, 8'h00, 1'b0);
		end
	endtask : setPtr
	task automatic wrByte(input logic [7:0] d);
		if (ptr == 1) begin
			cfg = d;
		end else if (ptr != 8'h48) begin
			wq.push_back({ptr[7:0], d});
			expMem[ptr] = d;
		end
		issue(CMD_WRITE, d, 1'b0);
		chk(nk, 0);
		ptr = adv(ptr);
	endtask : wrByte
	task automatic openRd();
		issue(CMD_START, 8'h00, 1'b0);
		issue(CMD_WRITE, {4'h7, strap, 2'b01}, 1'b0);
		chk(nk, 0);
		if (ptr != 1 && ptr != 8'h48) begin
			reExp++;
		end
	endtask : openRd
	task automatic rdByte(input logic a);
		int e;
		e = (ptr == 1) ? cfg : (ptr == 8'h48) ? flag : expMem[ptr];
		issue(CMD_READ, 8'h00, a);
		chk(q, e);
		if (ptr == 8'h48) begin
			flag = 0;
		end
		ptr = adv(ptr);
		// An acknowledged byte makes the device fetch the next one at once.
		if (a && ptr != 1 && ptr != 8'h48) begin
			reExp++;
		end
	endtask : rdByte
	initial begin
		repeat (40000) @(posedge mclk);
		error_cnt++;
		close_out();
	end
	initial begin
		for (int s = 0; s < 4; s++) begin
			strap <= s[1:0];
			doReset();
			issue(CMD_START, 8'h00, 1'b0);
			issue(CMD_WRITE, {4'h7, strap, 2'b10}, 1'b0);
			chk(nk, 1);
			setPtr(8'h5a, 1);
		end
		setPtr(8'h5a, 0);
		repeat (3) begin
			seed = lfsr(seed);
			wrByte(seed[7:0]);
		end
		issue(CMD_STOP, 8'h00, 1'b0);
		setPtr(8'h10, 0);
		repeat (2) begin
			seed = lfsr(seed);
			wrByte(seed[7:0]);
		end
		issue(CMD_STOP, 8'h00, 1'b0);
		setPtr(8'h5b, 0);
		openRd();
		rdByte(1'b1);
		rdByte(1'b1);
		rdByte(1'b0);
		issue(CMD_STOP, 8'h00, 1'b0);
		setPtr(1, 0);
		openRd();
		rdByte(1'b0);
		setPtr(1, 0);
		wrByte(8'h0b);
		repeat (TO_CYC + 200) @(posedge mclk);
		chk(timeoutFlag, 0);
		wrByte(8'h0a);
		setPtr(8'h31, 0);
		wrByte(8'h25);
		wrByte(8'h13);
		setPtr(8'h31, 0);
		openRd();
		rdByte(1'b1);
		// Device now holds the low first bit of the next byte while the clock stalls.
		repeat (TO_CYC + 200) @(posedge mclk);
		flag = 1;
		chk(busIf.sdaOeS, 0);
		chk(timeoutFlag, 1);
		chk(intPull, 1);
		issue(CMD_WRITE, 8'h55, 1'b0);
		chk(nk, 1);
		setPtr(8'h48, 0);
		openRd();
		rdByte(1'b0);
		issue(CMD_STOP, 8'h00, 1'b0);
		chk(timeoutFlag, 0);
		chk(intPull, 0);
		portEvent <= 1'b1;
		repeat (2) @(posedge mclk);
		chk(intPull, 1);
		portEvent <= 1'b0;
		repeat (2) @(posedge mclk);
		chk(wq.size(), 0);
		chk(reCnt, reExp);
		close_out();
	end
endmodule : tb_top
